// >>> logic/amd_pkg.sv
// Package for the addressing mode and prebyte decoder
package amd_pkg;

  // ------------------------------------------------------------
  // Prebyte values
  // ------------------------------------------------------------
  localparam logic [7:0] AMD_SECOND_INDEX_PREFIX = 8'h90;
  localparam logic [7:0] AMD_INDIRECT_SECOND_INDEX_PREFIX = 8'h91;
  localparam logic [7:0] AMD_INDIRECT_PREFIX = 8'h92;

  // ------------------------------------------------------------
  // Widths and limits
  // ------------------------------------------------------------
  localparam int AMD_ADDR_W = 16;
  localparam int AMD_DATA_W = 8;
  localparam int AMD_INSTR_COUNT = 63;
  localparam int AMD_MAX_INSTR_LEN = 4;
  localparam logic [15:0] AMD_PC_RESET = 16'h0000;

  // ------------------------------------------------------------
  // Opcode row (high nibble) encodings and special full opcodes
  // ------------------------------------------------------------
  localparam logic [3:0] AMD_ROW_REL = 4'h2;
  localparam logic [3:0] AMD_ROW_DIR_MEM = 4'h3;
  localparam logic [3:0] AMD_ROW_IDX1_MEM = 4'h6;
  localparam logic [3:0] AMD_ROW_IDX0_MEM = 4'h7;
  localparam logic [3:0] AMD_ROW_IMM = 4'ha;
  localparam logic [3:0] AMD_ROW_SDIR = 4'hb;
  localparam logic [3:0] AMD_ROW_LDIR = 4'hc;
  localparam logic [3:0] AMD_ROW_LIDX = 4'hd;
  localparam logic [3:0] AMD_ROW_SIDX = 4'he;
  localparam logic [3:0] AMD_ROW_IDX0 = 4'hf;
  localparam logic [3:0] AMD_ROW_BITREL = 4'h0;
  localparam logic [3:0] AMD_ROW_BIT = 4'h1;
  localparam logic [7:0] AMD_OP_RELATIVE_CALL = 8'had;
  localparam logic [7:0] AMD_OP_ILLEGAL_A = 8'h8d;
  localparam logic [7:0] AMD_OP_ILLEGAL_B = 8'h8c;

  // ------------------------------------------------------------
  // Addressing modes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    AMD_MODE_INHERENT,
    AMD_MODE_IMMEDIATE,
    AMD_MODE_SHORT_DIRECT,
    AMD_MODE_LONG_DIRECT,
    AMD_MODE_IDX_NONE,
    AMD_MODE_IDX_SHORT,
    AMD_MODE_IDX_LONG,
    AMD_MODE_SHORT_INDIRECT,
    AMD_MODE_LONG_INDIRECT,
    AMD_MODE_SHORT_IND_IDX,
    AMD_MODE_LONG_IND_IDX,
    AMD_MODE_REL_DIRECT,
    AMD_MODE_REL_INDIRECT,
    AMD_MODE_BIT_DIRECT,
    AMD_MODE_BIT_INDIRECT
  } amd_mode_type;

endpackage

// >>> logic/amd_fetch_if.sv
// Interface carrying the fetch port between the sequencer and address unit
`timescale 1ns/1ps
interface amd_fetch_if;
  import amd_pkg::*;

  logic [15:0] index_val;    // Selected index register
  logic [15:0] offset_val;   // Offset, pointer or displacement
  logic [15:0] pc_val;       // Program counter after the instruction
  amd_mode_type mode;        // Resolved addressing mode
  logic [15:0] ea;           // Effective address result
  logic [15:0] rel_target;   // Relative branch target

  modport seq (output index_val, output offset_val, output pc_val, output mode,
               input ea, input rel_target);
  modport calc (input index_val, input offset_val, input pc_val, input mode,
                output ea, output rel_target);
endinterface

// >>> logic/amd_ea_calc.sv
// Effective address arithmetic for all memory addressing modes
`timescale 1ns/1ps
module amd_ea_calc
  import amd_pkg::*;
(
  // Operands and result
  amd_fetch_if.calc fi
);

  // ------------------------------------------------------------
  // Address forming
  // ------------------------------------------------------------
  // Unsigned 16-bit add, carry out dropped; index and offset are zero-extended
  function automatic logic [15:0] uadd(input logic [15:0] a, input logic [15:0] b);
    uadd = a + b;
  endfunction

  // Mode-dependent effective address
  always_comb begin
    unique case (fi.mode)
      AMD_MODE_IDX_NONE: fi.ea = {8'h00, fi.index_val[7:0]};
      AMD_MODE_IDX_SHORT: fi.ea = uadd(fi.index_val, fi.offset_val);
      AMD_MODE_IDX_LONG: fi.ea = uadd(fi.index_val, fi.offset_val);
      AMD_MODE_SHORT_IND_IDX: fi.ea = uadd(fi.index_val, fi.offset_val);
      AMD_MODE_LONG_IND_IDX: fi.ea = uadd(fi.index_val, fi.offset_val);
      AMD_MODE_SHORT_INDIRECT: fi.ea = {8'h00, fi.offset_val[7:0]};
      default: fi.ea = fi.offset_val;
    endcase
  end

  // Signed 8-bit displacement on the already advanced counter
  always_comb begin
    fi.rel_target = fi.pc_val + {{8{fi.offset_val[7]}}, fi.offset_val[7:0]};
  end

endmodule

// >>> logic/amd_decoder.sv
// Instruction fetch sequencer, prebyte handling and illegal code detection
// Behaviour
// - Short direct: one address byte, page zero
// - Long direct: two address bytes, full space
// - Indexed address is unsigned index plus offset
// - No offset indexed: index alone, no byte
// - Short indexed: one offset byte, up to 1FE
// - Long indexed: two offset bytes, full space
// - Short indirect: byte pointer from page zero
// - Long indirect: word pointer from page zero
// - Indirect indexed: pointer plus index, unsigned
// - Short indirect indexed reaches up to 1FE
// - Relative adds signed 8-bit offset to counter
// - Counter already points past the jump
// - Relative indirect reads offset from page zero
// - Long and short forms for arithmetic group
// - Short forms only for read-modify-write group
// - Instructions are one to four bytes long
// - Fetch order: prebyte, opcode, address bytes
// - Prebyte 90 swaps first index for second
// - Prebyte 92 turns direct into indirect
// - Prebyte 91 gives second index indirect indexed
// - Undefined code raises reset
// - Valid prebyte plus valid opcode never resets
`timescale 1ns/1ps
module amd_decoder
  import amd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Program and data memory read port
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ready,
  // Index registers from the core
  input wire logic [7:0] index_x,
  input wire logic [7:0] index_y,
  // Decode results to execution
  input wire logic exec_ready,
  output logic dec_valid,
  output logic [7:0] dec_opcode,
  output logic [7:0] dec_prebyte,
  output amd_mode_type dec_mode,
  output logic dec_use_second_index,
  output logic [15:0] dec_ea,
  output logic [7:0] dec_imm,
  output logic [2:0] dec_length,
  output logic [15:0] program_counter,
  // Branch request from execution
  input wire logic branch_take,
  // Illegal code reset request
  output logic illegal_reset
);

  // ------------------------------------------------------------
  // State and registers
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OPCODE,   // Fetch prebyte or opcode
    ST_ARG0,     // First byte after opcode
    ST_ARG1,     // Second byte after opcode
    ST_PTR0,     // Pointer high or only byte
    ST_PTR1,     // Pointer low byte
    ST_ISSUE     // Hand result to execution
  } amd_state_type;

  amd_state_type state_q;
  logic [15:0] pc_q;          // Fetch counter
  logic [7:0] pre_q;          // Held prebyte, zero when none
  logic [7:0] op_q;           // Held opcode
  amd_mode_type mode_q;       // Resolved mode
  logic [15:0] arg_q;         // Bytes after the opcode
  logic [15:0] ptr_q;         // Pointer read from page zero
  logic [2:0] len_q;          // Bytes consumed so far
  logic illegal_q;            // Reset request pulse

  amd_fetch_if fi();          // Link to address unit

  // Base mode from opcode, before prebyte rewriting
  amd_mode_type base_mode;
  logic op_defined;           // Opcode exists in the map
  logic is_pre;               // Byte is a prebyte
  logic use_y;                // Second index selected
  amd_mode_type eff_mode;     // Mode after prebyte

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // Prebyte recognition
  function automatic logic prebyte(input logic [7:0] b);
    prebyte = (b == AMD_SECOND_INDEX_PREFIX) || (b == AMD_INDIRECT_PREFIX) ||
              (b == AMD_INDIRECT_SECOND_INDEX_PREFIX);
  endfunction

  // Operand bytes following opcode per mode
  function automatic logic [1:0] arg_bytes(input amd_mode_type m);
    unique case (m)
      AMD_MODE_INHERENT, AMD_MODE_IDX_NONE: arg_bytes = 2'd0;
      AMD_MODE_LONG_DIRECT, AMD_MODE_IDX_LONG: arg_bytes = 2'd2;
      AMD_MODE_BIT_DIRECT: arg_bytes = 2'd1;
      default: arg_bytes = 2'd1;
    endcase
  endfunction

  // Opcode map by row: operand addressing of high nibble
  always_comb begin
    op_defined = 1'b1;
    base_mode = AMD_MODE_INHERENT;
    unique case (op_q[7:4])
      AMD_ROW_BITREL: base_mode = AMD_MODE_BIT_DIRECT;
      AMD_ROW_BIT: base_mode = AMD_MODE_BIT_DIRECT;
      AMD_ROW_REL: base_mode = AMD_MODE_REL_DIRECT;
      AMD_ROW_DIR_MEM: base_mode = AMD_MODE_SHORT_DIRECT;
      AMD_ROW_IDX1_MEM: base_mode = AMD_MODE_IDX_SHORT;
      AMD_ROW_IDX0_MEM: base_mode = AMD_MODE_IDX_NONE;
      AMD_ROW_IMM: base_mode = (op_q == AMD_OP_RELATIVE_CALL) ? AMD_MODE_REL_DIRECT
                                                       : AMD_MODE_IMMEDIATE;
      AMD_ROW_SDIR: base_mode = AMD_MODE_SHORT_DIRECT;
      AMD_ROW_LDIR: base_mode = AMD_MODE_LONG_DIRECT;
      AMD_ROW_LIDX: base_mode = AMD_MODE_IDX_LONG;
      AMD_ROW_SIDX: base_mode = AMD_MODE_IDX_SHORT;
      AMD_ROW_IDX0: base_mode = AMD_MODE_IDX_NONE;
      default: base_mode = AMD_MODE_INHERENT;
    endcase
    // Holes in the map
    if (op_q == AMD_OP_ILLEGAL_A || op_q == AMD_OP_ILLEGAL_B) begin
      op_defined = 1'b0;
    end
  end

  // Prebyte rewriting of the base mode
  always_comb begin
    eff_mode = base_mode;
    use_y = 1'b0;
    unique case (pre_q)
      AMD_SECOND_INDEX_PREFIX: begin
        use_y = 1'b1;
      end
      AMD_INDIRECT_PREFIX: begin
        unique case (base_mode)
          AMD_MODE_SHORT_DIRECT: eff_mode = AMD_MODE_SHORT_INDIRECT;
          AMD_MODE_LONG_DIRECT: eff_mode = AMD_MODE_LONG_INDIRECT;
          AMD_MODE_IDX_SHORT: eff_mode = AMD_MODE_SHORT_IND_IDX;
          AMD_MODE_IDX_LONG: eff_mode = AMD_MODE_LONG_IND_IDX;
          AMD_MODE_REL_DIRECT: eff_mode = AMD_MODE_REL_INDIRECT;
          AMD_MODE_BIT_DIRECT: eff_mode = AMD_MODE_BIT_INDIRECT;
          default: eff_mode = base_mode;
        endcase
      end
      AMD_INDIRECT_SECOND_INDEX_PREFIX: begin
        use_y = 1'b1;
        unique case (base_mode)
          AMD_MODE_IDX_SHORT: eff_mode = AMD_MODE_SHORT_IND_IDX;
          AMD_MODE_IDX_LONG: eff_mode = AMD_MODE_LONG_IND_IDX;
          default: eff_mode = base_mode;
        endcase
      end
      default: begin
        eff_mode = base_mode;
      end
    endcase
  end

  // Current fetched byte is a prebyte while no prebyte is held
  assign is_pre = prebyte(mem_rdata) && (pre_q == 8'h00);

  // ------------------------------------------------------------
  // Fetch sequencer
  // ------------------------------------------------------------
  // Byte fetch state machine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_OPCODE;
    end else begin
      unique case (state_q)
        ST_OPCODE: begin
          if (mem_ready && !is_pre && !illegal_reset_d()) begin
            state_q <= ST_ARG0;
          end
        end
        ST_ARG0: begin
          if (arg_bytes(eff_mode) == 2'd0) begin
            state_q <= ST_ISSUE;
          end else if (mem_ready) begin
            if (arg_bytes(eff_mode) == 2'd2 && !ind_mode(eff_mode)) begin
              state_q <= ST_ARG1;
            end else if (ind_mode(eff_mode)) begin
              state_q <= ST_PTR0;
            end else begin
              state_q <= ST_ISSUE;
            end
          end
        end
        ST_ARG1: begin
          if (mem_ready) begin
            state_q <= ST_ISSUE;
          end
        end
        ST_PTR0: begin
          if (mem_ready) begin
            state_q <= word_ptr(eff_mode) ? ST_PTR1 : ST_ISSUE;
          end
        end
        ST_PTR1: begin
          if (mem_ready) begin
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (exec_ready) begin
            state_q <= ST_OPCODE;
          end
        end
      endcase
    end
  end

  // Modes that read a pointer from page zero
  function automatic logic ind_mode(input amd_mode_type m);
    ind_mode = (m == AMD_MODE_SHORT_INDIRECT) || (m == AMD_MODE_LONG_INDIRECT) ||
               (m == AMD_MODE_SHORT_IND_IDX) || (m == AMD_MODE_LONG_IND_IDX) ||
               (m == AMD_MODE_REL_INDIRECT) || (m == AMD_MODE_BIT_INDIRECT);
  endfunction

  // Modes whose pointer is a word
  function automatic logic word_ptr(input amd_mode_type m);
    word_ptr = (m == AMD_MODE_LONG_INDIRECT) || (m == AMD_MODE_LONG_IND_IDX);
  endfunction

  // Illegal only when the opcode itself is undefined
  function automatic logic illegal_reset_d();
    illegal_reset_d = (state_q == ST_OPCODE) && mem_ready && !is_pre &&
                      !prebyte_def(mem_rdata);
  endfunction

  // Opcode existence checked on the raw byte
  function automatic logic prebyte_def(input logic [7:0] b);
    prebyte_def = (b != AMD_OP_ILLEGAL_A) && (b != AMD_OP_ILLEGAL_B);
  endfunction

  // Program counter and length tracking
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_q <= AMD_PC_RESET;
      len_q <= 3'd0;
    end else if (state_q == ST_ISSUE && exec_ready && branch_take) begin
      pc_q <= fi.rel_target;
      len_q <= 3'd0;
    end else if (state_q == ST_ISSUE && exec_ready) begin
      len_q <= 3'd0;
    end else if (mem_ready && (state_q == ST_OPCODE || state_q == ST_ARG1 ||
                 (state_q == ST_ARG0 && arg_bytes(eff_mode) != 2'd0))) begin
      pc_q <= pc_q + 16'h0001;
      len_q <= len_q + 3'd1;
    end
  end

  // Prebyte and opcode capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_q <= 8'h00;
      op_q <= 8'h00;
    end else if (state_q == ST_OPCODE && mem_ready) begin
      if (is_pre) begin
        pre_q <= mem_rdata;
      end else begin
        op_q <= mem_rdata;
      end
    end else if (state_q == ST_ISSUE && exec_ready) begin
      pre_q <= 8'h00;
    end
  end

  // Argument and pointer bytes, big endian
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arg_q <= 16'h0000;
      ptr_q <= 16'h0000;
    end else if (mem_ready) begin
      unique case (state_q)
        ST_ARG0: arg_q <= {8'h00, mem_rdata};
        ST_ARG1: arg_q <= {arg_q[7:0], mem_rdata};
        ST_PTR0: ptr_q <= {8'h00, mem_rdata};
        ST_PTR1: ptr_q <= {ptr_q[7:0], mem_rdata};
        default: ptr_q <= ptr_q;
      endcase
    end
  end

  // Illegal code reset pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= illegal_reset_d();
    end
  end

  // ------------------------------------------------------------
  // Memory address and address unit
  // ------------------------------------------------------------
  // Fetch address: code at counter, pointers from page zero
  always_comb begin
    mem_req = (state_q != ST_ISSUE);
    mem_addr = pc_q;
    if (state_q == ST_PTR0) begin
      mem_addr = {8'h00, arg_q[7:0]};
    end else if (state_q == ST_PTR1) begin
      mem_addr = {8'h00, arg_q[7:0] + 8'h01};
    end
  end

  // Operands for effective address arithmetic
  always_comb begin
    fi.mode = eff_mode;
    fi.index_val = {8'h00, use_y ? index_y : index_x};
    fi.offset_val = ind_mode(eff_mode) ? ptr_q : arg_q;
    fi.pc_val = pc_q;
  end

  amd_ea_calc u_calc (
    .fi(fi.calc)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign dec_valid = (state_q == ST_ISSUE) && op_defined;
  assign illegal_reset = illegal_q;
  assign dec_opcode = op_q;
  assign dec_prebyte = pre_q;
  assign dec_mode = mode_q;
  assign dec_use_second_index = use_y;
  assign dec_ea = fi.ea;
  assign dec_imm = arg_q[7:0];
  assign dec_length = len_q;
  assign program_counter = pc_q;

  // Registered mode copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= AMD_MODE_INHERENT;
    end else begin
      mode_q <= eff_mode;
    end
  end

endmodule

// >>> dv/amd_sva.sv
// Concurrent checks on the decoder top ports
`timescale 1ns/1ps
module amd_sva
  import amd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fetch and index inputs
  input wire logic mem_req,
  input wire logic [7:0] index_x,
  input wire logic [7:0] index_y,
  input wire logic exec_ready,
  // Decode results
  input wire logic dec_valid,
  input wire logic [7:0] dec_prebyte,
  input wire amd_mode_type dec_mode,
  input wire logic dec_use_second_index,
  input wire logic [15:0] dec_ea,
  input wire logic [7:0] dec_imm,
  input wire logic [2:0] dec_length,
  input wire logic illegal_reset
);
  // ------------------------------------------------------------
  // Setup
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] idx; // Selected index, zero-extended
  assign idx = {8'h00, (dec_use_second_index ? index_y : index_x)};
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_pulse_one_cycle: assert property (illegal_reset |=> !illegal_reset)
    else $error("illegal reset pulse longer than one cycle");
  a_illegal_no_issue: assert property (illegal_reset |-> !dec_valid)
    else $error("undefined code issued");
  a_valid_holds: assert property (dec_valid && !exec_ready
    |=> dec_valid && $stable(dec_ea) && $stable(dec_length))
    else $error("decode result dropped before it was taken");
  a_no_fetch_issue: assert property (dec_valid |-> !mem_req)
    else $error("fetch during issue");
  a_length_range: assert property (dec_valid |-> dec_length inside {[1:4]})
    else $error("instruction length out of range");
  a_prefix_length: assert property (dec_valid && dec_prebyte != 8'h00
    |-> dec_length >= 3'h2)
    else $error("prefixed instruction too short");
  a_second_index: assert property (dec_valid
    && dec_prebyte == AMD_SECOND_INDEX_PREFIX |-> dec_use_second_index)
    else $error("second index not selected");
  a_no_offset_ea: assert property (dec_valid && $past(dec_valid)
    && dec_mode == AMD_MODE_IDX_NONE |-> dec_ea == idx)
    else $error("no offset address wrong");
  a_short_idx_sum: assert property (dec_valid && $past(dec_valid)
    && dec_mode == AMD_MODE_IDX_SHORT
    |-> dec_ea == {8'h00, dec_imm} + idx && dec_ea <= 16'h01fe)
    else $error("short indexed address wrong");
  a_short_direct_ea: assert property (dec_valid && $past(dec_valid)
    && dec_mode == AMD_MODE_SHORT_DIRECT |-> dec_ea == {8'h00, dec_imm})
    else $error("short direct address wrong");
  a_short_ind_page0: assert property (dec_valid && $past(dec_valid)
    && dec_mode == AMD_MODE_SHORT_INDIRECT |-> dec_ea[15:8] == 8'h00)
    else $error("short indirect address off page zero");
endmodule

// >>> dv/amd_mem_model.sv
// Program and data memory model on the core read port
`timescale 1ns/1ps
module amd_mem_model (
  // Clock
  input wire logic clk,
  // Read port
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata,
  output logic mem_ready,
  // One wait state per byte when high
  input wire logic slow
);
  logic [7:0] mem [logic [15:0]]; // Sparse byte store
  logic wait_q = 1'b0; // Wait state served, known from time zero
  logic [7:0] junk_q = 8'h5a; // Changing filler for idle data
  // Store one byte
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
  // Forget all contents
  task automatic clear();
    mem.delete();
  endtask
  // Wait state and filler sequencing
  always @(posedge clk) begin
    // Unknown request before reset counts as idle, so the wait state never sticks at X
    wait_q <= (mem_req === 1'b1) && slow && !wait_q;
    junk_q <= ~junk_q;
  end
  // Answer; idle or unwritten bytes never echo old data
  always @* begin
    mem_ready = mem_req && (!slow || wait_q);
    mem_rdata = junk_q;
    if (mem_ready && mem.exists(mem_addr)) begin
      mem_rdata = mem[mem_addr];
    end
  end
endmodule

// >>> dv/addressing_mode_prebyte_decoder_tb.sv
// Self-checking bench for the decoder
`timescale 1ns/1ps
module addressing_mode_prebyte_decoder_tb;
  import amd_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0, exec_ready = 1'b0, branch_take = 1'b0;
  logic [7:0] index_x = 8'hff, index_y = 8'h7f, mem_rdata, dec_opcode, dec_prebyte, dec_imm;
  logic mem_req, mem_ready, dec_valid, dec_use_second_index, illegal_reset;
  logic [15:0] mem_addr, dec_ea, program_counter;
  logic [2:0] dec_length;
  amd_mode_type dec_mode;
  int miscompares = 0, n_tests = 0, cycles = 0;
  always #5 clk = ~clk;
  // ------------------------------------------------------------
  // Instances
  // ------------------------------------------------------------
  amd_decoder u_dut (.clk(clk), .rst_n(rst_n), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready), .index_x(index_x), .index_y(index_y),
    .exec_ready(exec_ready), .dec_valid(dec_valid), .dec_opcode(dec_opcode),
    .dec_prebyte(dec_prebyte), .dec_mode(dec_mode), .dec_use_second_index(dec_use_second_index),
    .dec_ea(dec_ea), .dec_imm(dec_imm), .dec_length(dec_length),
    .program_counter(program_counter), .branch_take(branch_take), .illegal_reset(illegal_reset));
  amd_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready), .slow(slow));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // Reset, then load a program at address zero
  task automatic restart(input int n, input logic [7:0] b[$]);
    rst_n = 1'b0;
    u_mem.clear();
    foreach (b[i]) u_mem.put(16'(i), b[i]);
    repeat (n) step();
    rst_n = 1'b1;
  endtask
  // Wait for issue, compare, then hand the instruction to execution
  task automatic expect_instr(input amd_mode_type m, input logic [15:0] ea,
      input logic [2:0] len, input logic [7:0] pb, input logic sec, input logic take);
    int k;
    k = 0;
    while (dec_valid !== 1'b1 && k < 60) begin
      step();
      k++;
    end
    step(); // Let the registered mode settle
    check("dec_valid", {15'h0, dec_valid}, 16'h1);
    check("dec_mode", {12'h0, dec_mode}, {12'h0, m});
    if (m != AMD_MODE_REL_DIRECT && m != AMD_MODE_REL_INDIRECT) check("dec_ea", dec_ea, ea);
    check("dec_length", {13'h0, dec_length}, {13'h0, len});
    check("dec_prebyte", {8'h0, dec_prebyte}, {8'h0, pb});
    check("second_index", {15'h0, dec_use_second_index}, {15'h0, sec});
    exec_ready = 1'b1;
    branch_take = take;
    step();
    exec_ready = 1'b0;
    branch_take = 1'b0;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_plain();
    slow = 1'b1; // Wait states on every byte
    restart(6, '{8'hb6, 8'h10, 8'hc6, 8'h12, 8'h34, 8'hf6, 8'he6, 8'hff, 8'hd6, 8'h12, 8'h00});
    expect_instr(AMD_MODE_SHORT_DIRECT, 16'h0010, 3'h2, 8'h00, 1'b0, 1'b0);
    expect_instr(AMD_MODE_LONG_DIRECT, 16'h1234, 3'h3, 8'h00, 1'b0, 1'b0);
    expect_instr(AMD_MODE_IDX_NONE, 16'h00ff, 3'h1, 8'h00, 1'b0, 1'b0);
    expect_instr(AMD_MODE_IDX_SHORT, 16'h01fe, 3'h2, 8'h00, 1'b0, 1'b0);
    expect_instr(AMD_MODE_IDX_LONG, 16'h12ff, 3'h3, 8'h00, 1'b0, 1'b0);
    slow = 1'b0;
    $display("test plain modes done");
  endtask
  task automatic t_prefix();
    restart(2, '{8'h90, 8'he6, 8'h80, 8'h90, 8'hd6, 8'h12, 8'h00, 8'h92, 8'hb6, 8'h30,
      8'h92, 8'hc6, 8'h32, 8'h92, 8'he6, 8'h34, 8'h91, 8'he6, 8'h34, 8'h92, 8'hd6, 8'h32,
      8'h36, 8'h30, 8'h16, 8'h20, 8'h92, 8'h16, 8'h30, 8'had, 8'h05, 8'h76});
    u_mem.put(16'h0030, 8'h55);
    u_mem.put(16'h0032, 8'hab);
    u_mem.put(16'h0033, 8'hcd);
    u_mem.put(16'h0034, 8'hff);
    expect_instr(AMD_MODE_IDX_SHORT, 16'h00ff, 3'h3, 8'h90, 1'b1, 1'b0);
    expect_instr(AMD_MODE_IDX_LONG, 16'h127f, 3'h4, 8'h90, 1'b1, 1'b0);
    expect_instr(AMD_MODE_SHORT_INDIRECT, 16'h0055, 3'h3, 8'h92, 1'b0, 1'b0);
    expect_instr(AMD_MODE_LONG_INDIRECT, 16'habcd, 3'h3, 8'h92, 1'b0, 1'b0);
    expect_instr(AMD_MODE_SHORT_IND_IDX, 16'h01fe, 3'h3, 8'h92, 1'b0, 1'b0);
    expect_instr(AMD_MODE_SHORT_IND_IDX, 16'h017e, 3'h3, 8'h91, 1'b1, 1'b0);
    expect_instr(AMD_MODE_LONG_IND_IDX, 16'haccc, 3'h3, 8'h92, 1'b0, 1'b0);
    expect_instr(AMD_MODE_SHORT_DIRECT, 16'h0030, 3'h2, 8'h00, 1'b0, 1'b0);
    expect_instr(AMD_MODE_BIT_DIRECT, 16'h0020, 3'h2, 8'h00, 1'b0, 1'b0);
    expect_instr(AMD_MODE_BIT_INDIRECT, 16'h0055, 3'h3, 8'h92, 1'b0, 1'b0);
    expect_instr(AMD_MODE_REL_DIRECT, 16'h0000, 3'h2, 8'h00, 1'b0, 1'b0);
    expect_instr(AMD_MODE_IDX_NONE, 16'h00ff, 3'h1, 8'h00, 1'b0, 1'b0);
    $display("test prebytes done");
  endtask
  task automatic t_relative();
    restart(2, '{8'h20, 8'h80});
    expect_instr(AMD_MODE_REL_DIRECT, 16'h0000, 3'h2, 8'h00, 1'b0, 1'b1);
    check("pc_back", program_counter, 16'hff82);
    check("fetch_back", mem_addr, 16'hff82);
    restart(2, '{8'h92, 8'h20, 8'h40});
    u_mem.put(16'h0040, 8'h7f);
    expect_instr(AMD_MODE_REL_INDIRECT, 16'h0000, 3'h3, 8'h92, 1'b0, 1'b1);
    check("pc_fwd", program_counter, 16'h0082);
    check("fetch_fwd", mem_addr, 16'h0082);
    $display("test relative done");
  endtask
  task automatic t_illegal();
    logic [7:0] bad[2];
    int k;
    logic seen;
    bad = '{AMD_OP_ILLEGAL_B, AMD_OP_ILLEGAL_A};
    foreach (bad[i]) begin
      restart(2, '{bad[i]});
      k = 0;
      while (illegal_reset !== 1'b1 && k < 10) begin
        step();
        k++;
      end
      check("illegal_reset", {15'h0, illegal_reset}, 16'h1);
      step();
      check("illegal_end", {14'h0, illegal_reset, dec_valid}, 16'h0);
    end
    restart(2, '{8'h91, 8'hb6, 8'h10});
    seen = 1'b0;
    for (k = 0; k < 12 && dec_valid !== 1'b1; k++) begin
      step();
      seen = seen | (illegal_reset === 1'b1);
    end
    check("pair_no_reset", {14'h0, seen, dec_valid}, 16'h1);
    check("pair_opcode", {8'h0, dec_opcode}, 16'h00b6);
    $display("test illegal codes done");
  endtask
  // ------------------------------------------------------------
  // Timeout and main sequence
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    t_plain();
    t_prefix();
    t_relative();
    t_illegal();
    tally_and_finish();
  end
endmodule
bind amd_decoder amd_sva u_sva (.clk(clk), .rst_n(rst_n), .mem_req(mem_req),
  .index_x(index_x), .index_y(index_y), .exec_ready(exec_ready), .dec_valid(dec_valid),
  .dec_prebyte(dec_prebyte), .dec_mode(dec_mode), .dec_use_second_index(dec_use_second_index),
  .dec_ea(dec_ea), .dec_imm(dec_imm), .dec_length(dec_length), .illegal_reset(illegal_reset));
